// ### src/hpio_params.svh
// constants for the host bus parallel i/o port
`ifndef HPIO_PARAMS_SVH
`define HPIO_PARAMS_SVH
// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define HPIO_IDX_CSR 5'd0
`define HPIO_IDX_OUTW 5'd2
`define HPIO_IDX_OUTX 5'd4
`define HPIO_IDX_IN0 5'd6
`define HPIO_IDX_IN1 5'd8
`define HPIO_IDX_IN2 5'd10
`define HPIO_IDX_ISTAT 5'd12
`define HPIO_IDX_ICLR 5'd14
`define HPIO_IDX_IEN 5'd16
`define HPIO_IDX_STBW 5'd18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HPIO_CSR_FLAG 7
`define HPIO_CSR_IEN 6
`define HPIO_CSR_ST0 11
`define HPIO_CSR_ST1 13
`define HPIO_CSR_ST2 14
`define HPIO_SRC_RX 0
`define HPIO_SRC_TX 1
// synchronised pin vector layout
`define HPIO_PIN_W 40
`define HPIO_P_RXR 34
`define HPIO_P_TXR 35
`define HPIO_P_GNT 39
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPIO_CLK_NS 10
`define HPIO_STB_NS 100
`define HPIO_STB_CYC ((`HPIO_STB_NS + `HPIO_CLK_NS - 1) / `HPIO_CLK_NS)
`endif

// ### src/hpio_pkg.sv
// types for the host bus parallel i/o port
package hpio_pkg;
  // interrupt controller states
  typedef enum logic [1:0] {
    HPIO_IC_IDLE = 2'b00,
    HPIO_IC_REQ = 2'b01,
    HPIO_IC_VEC = 2'b10,
    HPIO_IC_DONE = 2'b11
  } hpio_ic_t;

  // whole block state
  typedef struct packed {
    logic [39:0] pin_s1;
    logic [39:0] pin_s2;
    logic [39:0] pin_s3;
    logic [39:0] pin_f;
    logic [1:0] rdy_prev;
    logic [7:0] out_lo;
    logic [7:0] out_hi;
    logic [7:0] out_ext;
    logic [7:0] stb_width;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [1:0] pend;
    hpio_ic_t icst;
    logic vec_src;
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic tx_stb;
    logic rx_stb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic bus_req;
    logic [8:0] vector;
    logic vec_vld;
    logic grant_out;
  } hpio_state_t;
endpackage : hpio_pkg

// ### src/hpio_top.sv
// parallel i/o port: apb registers, instrument pins, interrupt controller
`timescale 1ns/100ps
`include "hpio_params.svh"

module hpio_top #(
  parameter logic [17:0] BASE_ADDR = 18'h0_0000,
  // vector base bits 8:2, value arbitrary
  parameter logic [6:0] VEC_BASE = 7'h10
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // system bus initialize
  input wire logic BUS_INIT,
  // instrument side
  input wire logic [33:0] IN_DATA,
  input wire logic RX_READY,
  input wire logic TX_READY,
  input wire logic [2:0] USER_STATUS,
  output logic [23:0] CTRL_OUT,
  output logic TX_STROBE,
  output logic RX_STROBE,
  // interrupt lines and controller
  output logic RX_IRQ_REQUEST,
  output logic RX_IRQ_ENABLE,
  output logic TX_IRQ_REQUEST,
  output logic TX_IRQ_ENABLE,
  output logic IRQ,
  output logic BUS_REQ,
  input wire logic GRANT_IN,
  output logic GRANT_OUT,
  output logic [8:0] VECTOR,
  output logic VECTOR_VALID
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q; // release shifter
  logic rst_n; // synchronised reset

  // assert at once, release after two edges
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // state and decode terms
  // ----------------------------------------------------------------
  hpio_pkg::hpio_state_t st; // registered state
  hpio_pkg::hpio_state_t next_st; // next state
  logic [4:0] ix; // word index
  logic hit; // address belongs to us
  logic setup; // apb setup cycle
  logic wr; // write completes this edge
  logic [31:0] rdat; // read mux
  logic [39:0] agree; // second and third stage agree
  logic [1:0] rdy_rise; // ready events
  logic [1:0] clr; // clear requests
  logic [7:0] wmin; // strobe width, at least one
  logic slice_end; // last input slice read

  assign ix = PADDR[6:2];
  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & st.pready & PWRITE & hit;
  assign agree = ~(st.pin_s2 ^ st.pin_s3);
  assign wmin = (st.stb_width == 8'h00) ? 8'h01 : st.stb_width;

  // full address plus alignment must match one register
  always_comb begin
    hit = 1'b0;
    if (PADDR[17:7] != BASE_ADDR[17:7] || PADDR[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (ix == `HPIO_IDX_CSR || ix == `HPIO_IDX_OUTW) begin
      hit = 1'b1;
    end else if (ix == `HPIO_IDX_OUTX || ix == `HPIO_IDX_IN0) begin
      hit = 1'b1;
    end else if (ix == `HPIO_IDX_IN1 || ix == `HPIO_IDX_IN2) begin
      hit = 1'b1;
    end else if (ix == `HPIO_IDX_ISTAT || ix == `HPIO_IDX_ICLR) begin
      hit = 1'b1;
    end else if (ix == `HPIO_IDX_IEN || ix == `HPIO_IDX_STBW) begin
      hit = 1'b1;
    end
  end

  // read mux: one select per index except ICLR, which reads zero
  always_comb begin
    rdat = 32'h0000_0000;
    if (ix == `HPIO_IDX_CSR) begin
      rdat[`HPIO_CSR_ST0] = st.pin_f[36];
      rdat[`HPIO_CSR_ST1] = st.pin_f[37];
      rdat[`HPIO_CSR_ST2] = st.pin_f[38];
      rdat[`HPIO_CSR_FLAG] = st.irq_stat[`HPIO_SRC_TX];
      rdat[`HPIO_CSR_IEN] = st.irq_en[`HPIO_SRC_TX];
    end else if (ix == `HPIO_IDX_OUTW) begin
      rdat[15:0] = {st.out_hi, st.out_lo};
    end else if (ix == `HPIO_IDX_OUTX) begin
      rdat[7:0] = st.out_ext;
    end else if (ix == `HPIO_IDX_IN0) begin
      rdat[11:0] = st.pin_f[11:0];
    end else if (ix == `HPIO_IDX_IN1) begin
      rdat[15:0] = st.pin_f[27:12];
    end else if (ix == `HPIO_IDX_IN2) begin
      rdat[5:0] = st.pin_f[33:28];
    end else if (ix == `HPIO_IDX_ISTAT) begin
      rdat[1:0] = st.irq_stat;
    end else if (ix == `HPIO_IDX_IEN) begin
      rdat[1:0] = st.irq_en;
    end else if (ix == `HPIO_IDX_STBW) begin
      rdat[7:0] = st.stb_width;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    rdy_rise = 2'b00;
    clr = 2'b00;
    slice_end = 1'b0;
    if (CE) begin
      // pins pass three stages; a change counts once two agree
      next_st.pin_s1 = {GRANT_IN, USER_STATUS, TX_READY, RX_READY,
                        IN_DATA};
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      next_st.pin_f = (st.pin_s2 & agree) | (st.pin_f & ~agree);
      // ready edges become sticky events
      next_st.rdy_prev = {st.pin_f[`HPIO_P_TXR], st.pin_f[`HPIO_P_RXR]};
      rdy_rise = {st.pin_f[`HPIO_P_TXR], st.pin_f[`HPIO_P_RXR]}
                 & ~st.rdy_prev;
      // apb answers in the first access cycle, data from a flop
      next_st.pready = setup;
      next_st.pslverr = setup & ~hit;
      next_st.prdata = (setup & ~PWRITE & hit) ? rdat
                       : 32'h0000_0000;
      slice_end = PSEL & PENABLE & st.pready & ~PWRITE & hit
                  & (ix == `HPIO_IDX_IN2);
      // register writes land at the completing access edge
      if (wr && ix == `HPIO_IDX_OUTW) begin
        if (PSTRB[0]) begin
          next_st.out_lo = PWDATA[7:0];
        end
        if (PSTRB[1]) begin
          next_st.out_hi = PWDATA[15:8];
        end
      end
      if (wr && ix == `HPIO_IDX_OUTX && PSTRB[0]) begin
        next_st.out_ext = PWDATA[7:0];
      end
      if (wr && ix == `HPIO_IDX_CSR && PSTRB[0]) begin
        next_st.irq_en[`HPIO_SRC_TX] = PWDATA[`HPIO_CSR_IEN];
      end
      if (wr && ix == `HPIO_IDX_IEN && PSTRB[0]) begin
        next_st.irq_en = PWDATA[1:0];
      end
      if (wr && ix == `HPIO_IDX_STBW && PSTRB[0]) begin
        next_st.stb_width = PWDATA[7:0];
      end
      if (wr && ix == `HPIO_IDX_ICLR && PSTRB[0]) begin
        clr = PWDATA[1:0];
      end
      // an event in the clearing cycle still sets its bit
      next_st.irq_stat = (st.irq_stat & ~clr) | rdy_rise;
      next_st.pend = (st.pend & ~clr) | rdy_rise;
      next_st.irq = |(st.irq_stat & st.irq_en);
      // output one-shot fires on any apb update of the output registers
      if (wr && (ix == `HPIO_IDX_OUTW || ix == `HPIO_IDX_OUTX)
          && (PSTRB[1:0] != 2'b00)) begin
        next_st.tx_stb = 1'b1;
        next_st.tx_cnt = wmin - 8'h01;
      end else if (st.tx_cnt != 8'h00) begin
        next_st.tx_cnt = st.tx_cnt - 8'h01;
      end else begin
        next_st.tx_stb = 1'b0;
      end
      // input one-shot tells the instrument its word was taken
      if (slice_end) begin
        next_st.rx_stb = 1'b1;
        next_st.rx_cnt = wmin - 8'h01;
      end else if (st.rx_cnt != 8'h00) begin
        next_st.rx_cnt = st.rx_cnt - 8'h01;
      end else begin
        next_st.rx_stb = 1'b0;
      end
      // interrupt controller: request, take grant, present vector
      next_st.vec_vld = 1'b0;
      case (st.icst)
        hpio_pkg::HPIO_IC_IDLE: begin
          if ((st.pend & st.irq_en) != 2'b00) begin
            next_st.bus_req = 1'b1;
            next_st.vec_src = ~(st.pend[0] & st.irq_en[0]);
            next_st.icst = hpio_pkg::HPIO_IC_REQ;
          end
        end
        hpio_pkg::HPIO_IC_REQ: begin
          if (st.pin_f[`HPIO_P_GNT]) begin
            next_st.vector = {VEC_BASE + {6'h00, st.vec_src}, 2'b00};
            next_st.vec_vld = 1'b1;
            next_st.icst = hpio_pkg::HPIO_IC_VEC;
          end
        end
        hpio_pkg::HPIO_IC_VEC: begin
          next_st.bus_req = 1'b0;
          next_st.pend[st.vec_src] = rdy_rise[st.vec_src];
          next_st.icst = hpio_pkg::HPIO_IC_DONE;
        end
        hpio_pkg::HPIO_IC_DONE: begin
          // wait for the grant to drop before asking again
          if (!st.pin_f[`HPIO_P_GNT]) begin
            next_st.icst = hpio_pkg::HPIO_IC_IDLE;
          end
        end
        default: begin
          next_st.icst = hpio_pkg::HPIO_IC_IDLE;
        end
      endcase
      // daisy chain: pass the grant on only when not asking
      next_st.grant_out = st.pin_f[`HPIO_P_GNT]
                          & (st.icst == hpio_pkg::HPIO_IC_IDLE)
                          & ~next_st.bus_req;
      // bus initialize wins over the output, enable, pending, status and request updates above
      if (BUS_INIT) begin
        next_st.out_lo = 8'h00;
        next_st.out_hi = 8'h00;
        next_st.out_ext = 8'h00;
        next_st.irq_en = 2'b00;
        next_st.pend = 2'b00;
        next_st.irq_stat = 2'b00;
        next_st.bus_req = 1'b0;
        next_st.icst = hpio_pkg::HPIO_IC_IDLE;
      end
    end
  end

  // state register; reset takes constants only
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.stb_width <= 8'(`HPIO_STB_CYC);
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign CTRL_OUT = {st.out_ext, st.out_hi, st.out_lo};
  assign TX_STROBE = st.tx_stb;
  assign RX_STROBE = st.rx_stb;
  assign RX_IRQ_REQUEST = st.irq_stat[`HPIO_SRC_RX];
  assign RX_IRQ_ENABLE = st.irq_en[`HPIO_SRC_RX];
  assign TX_IRQ_REQUEST = st.irq_stat[`HPIO_SRC_TX];
  assign TX_IRQ_ENABLE = st.irq_en[`HPIO_SRC_TX];
  assign IRQ = st.irq;
  assign BUS_REQ = st.bus_req;
  assign GRANT_OUT = st.grant_out;
  assign VECTOR = st.vector;
  assign VECTOR_VALID = st.vec_vld;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_slice0;
    @(posedge CLK) disable iff (!rst_n || !CE)
    (setup && hit && !PWRITE && ix == `HPIO_IDX_IN0)
      |=> PRDATA == {20'h0_0000, $past(st.pin_f[11:0])};
  endproperty
  a_slice0: assert property (p_slice0) else $error("slice 0 wrong");

  property p_idle_data;
    @(posedge CLK) disable iff (!rst_n || !CE)
    !PREADY |-> PRDATA == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("data leak");

  property p_byte_hi;
    @(posedge CLK) disable iff (!rst_n || !CE)
    (wr && !BUS_INIT && ix == `HPIO_IDX_OUTW && PSTRB == 4'b0010)
      |=> CTRL_OUT[15:8] == $past(PWDATA[15:8])
          && CTRL_OUT[7:0] == $past(CTRL_OUT[7:0]);
  endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("high byte");

  property p_word;
    @(posedge CLK) disable iff (!rst_n || !CE)
    (wr && !BUS_INIT && ix == `HPIO_IDX_OUTW && PSTRB == 4'b0011)
      |=> CTRL_OUT[15:0] == $past(PWDATA[15:0]) ##0 TX_STROBE;
  endproperty
  a_word: assert property (p_word) else $error("word write");

  property p_width;
    @(posedge CLK) disable iff (!rst_n || !CE)
    $rose(TX_STROBE) && st.stb_width == 8'h03
      |-> TX_STROBE [*3] ##1 !TX_STROBE;
  endproperty
  a_width: assert property (p_width) else $error("strobe width");

  property p_tx_irq;
    @(posedge CLK) disable iff (!rst_n || !CE || BUS_INIT)
    (TX_IRQ_REQUEST && TX_IRQ_ENABLE) |=> IRQ;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("irq missing");

  property p_vector;
    @(posedge CLK) disable iff (!rst_n || !CE)
    VECTOR_VALID |-> BUS_REQ && VECTOR[1:0] == 2'b00 && $past(BUS_REQ);
  endproperty
  a_vector: assert property (p_vector) else $error("vector");

  property p_chain;
    @(posedge CLK) disable iff (!rst_n || !CE)
    GRANT_OUT |-> !BUS_REQ;
  endproperty
  a_chain: assert property (p_chain) else $error("grant passed");

  property p_init;
    @(posedge CLK) disable iff (!rst_n || !CE)
    BUS_INIT |=> CTRL_OUT == 24'h00_0000 && !RX_IRQ_ENABLE
                 && !TX_IRQ_ENABLE && !BUS_REQ;
  endproperty
  a_init: assert property (p_init) else $error("init");

endmodule : hpio_top

// ### tb/hpio_host_model.sv
// host side model: answers controller bus requests with a grant
`timescale 1ns/100ps

module hpio_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // grant handshake
  input wire logic bus_req,
  input wire logic slow,
  output logic grant
);
  // cycles waited before granting
  logic [3:0] wait_cnt;

  // grant after a prompt or slow delay, hold until request drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= 4'h0;
      grant <= 1'b0;
    end else if (!bus_req) begin
      // request gone: release so the chain goes idle
      wait_cnt <= 4'h0;
      grant <= 1'b0;
    end else if (!grant) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= (slow ? 4'hc : 4'h1)) begin
        grant <= 1'b1;
      end
    end
  end
endmodule : hpio_host_model

// ### tb/test_hpio_top.sv
// self-checking bench for the parallel i/o port
`timescale 1ns/100ps
`include "hpio_params.svh"

module test_hpio_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // vector base, value arbitrary
  localparam logic [6:0] VB = 7'h10;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, perr, binit = 1'b0, slow = 1'b0, ce = 1'b1;
  // grant handed down by a device nearer the processor
  logic xgnt = 1'b0;
  logic [33:0] in_data = '0;
  logic rx_rdy = 1'b0, tx_rdy = 1'b0;
  logic [2:0] ust = '0;
  logic [23:0] ctrl;
  logic tx_stb, rx_stb, rx_req, rx_en, tx_req, tx_en, irq;
  logic breq, gnt, gnt_out, vvld;
  logic [8:0] vec;
  logic [31:0] seed = 32'h0000_9da3;
  int n_fail = 0, checks = 0, n_tx = 0, n_rx = 0;
  // bad places: unmapped, misaligned, wrong base
  logic [17:0] bad [4] = '{18'h0_0004, 18'h0_0050, 18'h0_001a, 18'h1_0008};

  hpio_top #(.VEC_BASE(VB)) uut (
    .CLK(clk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUS_INIT(binit), .IN_DATA(in_data), .RX_READY(rx_rdy),
    .TX_READY(tx_rdy), .USER_STATUS(ust), .CTRL_OUT(ctrl),
    .TX_STROBE(tx_stb), .RX_STROBE(rx_stb), .RX_IRQ_REQUEST(rx_req),
    .RX_IRQ_ENABLE(rx_en), .TX_IRQ_REQUEST(tx_req),
    .TX_IRQ_ENABLE(tx_en), .IRQ(irq), .BUS_REQ(breq), .GRANT_IN(gnt | xgnt),
    .GRANT_OUT(gnt_out), .VECTOR(vec), .VECTOR_VALID(vvld));

  hpio_host_model host (.clk(clk), .rstn(rstn), .bus_req(breq),
    .slow(slow), .grant(gnt));

  // 100 mhz clock
  always #5 clk = ~clk;

  // strobe cycle counters, so pulse widths can be judged afterwards
  always @(posedge clk) begin
    n_tx <= n_tx + int'(tx_stb);
    n_rx <= n_rx + int'(rx_stb);
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // byte address of a register index
  function automatic logic [17:0] adr(logic [4:0] i);
    return {11'h000, i, 2'b00};
  endfunction : adr

  // expected input slice for read k
  function automatic logic [31:0] slc(logic [33:0] v, int k);
    case (k)
      0: return {20'h0_0000, v[11:0]};
      1: return {16'h0000, v[27:12]};
      default: return {26'h000_0000, v[33:28]};
    endcase
  endfunction : slc

  // output registers after a write with lane strobes
  function automatic logic [23:0] upd(logic [23:0] o, logic x,
      logic [31:0] d, logic [3:0] s);
    if (x) begin
      if (s[0]) o[23:16] = d[7:0];
    end else begin
      if (s[0]) o[7:0] = d[7:0];
      if (s[1]) o[15:8] = d[15:8];
    end
    return o;
  endfunction : upd

  // expected status word
  function automatic logic [31:0] csr(logic [2:0] s, logic f, logic e);
    return (32'(s[2]) << 14) | (32'(s[1]) << 13) | (32'(s[0]) << 11) |
      (32'(f) << 7) | (32'(e) << 6);
  endfunction : csr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [17:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    // no cycle count assumed: only the watchdog ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  // bounded wait for irq (sel low) or vector valid (sel high)
  task automatic wt(input logic sel);
    int n;
    n = 0;
    while ((sel ? vvld : irq) !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(sel ? vvld : irq, 1'b1);
  endtask : wt

  task automatic end_sim();
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // hang guard, far beyond the expected run
  initial begin
    #200_000;
    n_fail++;
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r, d;
    logic [23:0] eo;
    logic [3:0] s;
    int b;
    eo = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(ctrl, 0);
    apb(0, adr(`HPIO_IDX_STBW), 0, 0, r);
    chk(r, 32'h0000_000a);
    // input slices, all ones first then random
    for (int i = 0; i < 4; i++) begin
      in_data <= (i == 0) ? '1 : 34'({rnd(), rnd()});
      repeat (12) @(posedge clk);
      b = n_rx;
      for (int k = 0; k < 3; k++) begin
        apb(0, adr(5'(`HPIO_IDX_IN0 + 2 * k)), 0, 0, r);
        chk(r, slc(in_data, k));
      end
      repeat (12) @(posedge clk);
      chk(n_rx - b, 10);
    end
    // output registers, byte and word writes, strobe width 3
    apb(1, adr(`HPIO_IDX_STBW), 3, 1, r);
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      // even passes: word, then a lone high byte, then random lanes; odd passes write the extended byte
      s = i[0] ? 4'h1 : (i == 0) ? 4'h3 : (i == 2) ? 4'h2
        : 4'(rnd() % 3 + 1);
      b = n_tx;
      apb(1, adr(i[0] ? `HPIO_IDX_OUTX : `HPIO_IDX_OUTW), d, s, r);
      eo = upd(eo, i[0], d, s);
      repeat (6) @(posedge clk);
      chk(ctrl, eo);
      chk(n_tx - b, 3);
      apb(0, adr(`HPIO_IDX_OUTW), 0, 0, r);
      chk(r, eo[15:0]);
      apb(0, adr(`HPIO_IDX_OUTX), 0, 0, r);
      chk(r, eo[23:16]);
    end
    // refused places leave outputs alone
    foreach (bad[k]) begin
      apb(1, bad[k], '1, 4'hf, r);
      chk(perr, 1);
    end
    chk(ctrl, eo);
    // input interrupt with prompt grant
    apb(1, adr(`HPIO_IDX_IEN), 1, 1, r);
    rx_rdy <= 1'b1;
    wt(1'b0);
    chk({rx_req, rx_en}, 2'b11);
    wt(1'b1);
    chk(vec, {VB, 2'b00});
    apb(0, adr(`HPIO_IDX_ISTAT), 0, 0, r);
    chk(r, 1);
    apb(1, adr(`HPIO_IDX_ICLR), 1, 1, r);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    // output ready masked, then enabled with a slow grant
    rx_rdy <= 1'b0;
    tx_rdy <= 1'b1;
    slow <= 1'b1;
    repeat (12) @(posedge clk);
    chk({tx_req, irq, breq}, 3'b100);
    apb(1, adr(`HPIO_IDX_IEN), 3, 1, r);
    wt(1'b1);
    chk(vec, {VB + 7'h01, 2'b00});
    ust <= 3'(rnd());
    repeat (8) @(posedge clk);
    apb(0, adr(`HPIO_IDX_CSR), 0, 0, r);
    chk(r, csr(ust, 1, 1));
    // enable bit of the status register is writable, flag is not
    apb(1, adr(`HPIO_IDX_CSR), 0, 1, r);
    apb(0, adr(`HPIO_IDX_CSR), 0, 0, r);
    chk(r, csr(ust, 1, 0));
    // bus initialize, first held off by a low clock enable
    ce <= 1'b0;
    binit <= 1'b1;
    repeat (2) @(posedge clk);
    chk(ctrl, eo);
    ce <= 1'b1;
    @(posedge clk);
    binit <= 1'b0;
    repeat (2) @(posedge clk);
    chk({ctrl, tx_en, rx_en, tx_req, irq}, 0);
    // a grant from a nearer device passes on while idle
    xgnt <= 1'b1;
    repeat (6) @(posedge clk);
    chk(gnt_out, 1);
    xgnt <= 1'b0;
    repeat (6) @(posedge clk);
    chk(gnt_out, 0);
    end_sim();
  end
endmodule : test_hpio_top
